// ---- rtl/host_address_decoder.sv ----
// Purpose: Host-side glue that decodes a multiplexed host bus into chip select,
//          register select and strobes for an acquisition chip and peers.
// Assumes: Host pins are asynchronous to clk_sys and pass three flops here.
// Notes:   Full or minimal decoding chosen by a static mode input.
module host_address_decoder
  import addr_decode_pkg::*;
#(
  parameter logic [7:0] RANGE_SEL_DEFAULT = RANGE_DEFAULT
) (
  input  wire logic                       clk_sys,
  input  wire logic                       reset_n,
  input  wire addr_decode_pkg::decode_mode_t decode_mode,
  input  wire logic                       bus_width_select,
  input  wire logic [7:0]                 range_select_jumpers,
  input  wire logic                       range_use_default,
  input  wire addr_decode_pkg::host_bus_t host_bus,
  input  wire logic                       chip_irq_n,
  output addr_decode_pkg::chip_port_t     chip_port,
  output logic                            host_external_irq_line,
  output logic [DEC_OUTS-2:0]             peripheral_sel_n
);
  import addr_decode_pkg::*;

  localparam int HB_W = $bits(host_bus_t);

  // Three-stage synchronisers for the host bus and the chip interrupt
  host_bus_t hb_s1_r, hb_s2_r, hb_s3_r;
  logic      irq_s1_r, irq_s2_r, irq_s3_r;
  host_bus_t hb_r;          // Agreed host bus value
  logic      irq_r;

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      hb_s1_r  <= HB_W'(0) | host_bus_t'({16'h0000, 1'b0, 1'b1, 1'b1});
      hb_s2_r  <= host_bus_t'({16'h0000, 1'b0, 1'b1, 1'b1});
      hb_s3_r  <= host_bus_t'({16'h0000, 1'b0, 1'b1, 1'b1});
      irq_s1_r <= 1'b1;
      irq_s2_r <= 1'b1;
      irq_s3_r <= 1'b1;
    end
    else
    begin
      hb_s1_r  <= host_bus;
      hb_s2_r  <= hb_s1_r;
      hb_s3_r  <= hb_s2_r;
      irq_s1_r <= chip_irq_n;
      irq_s2_r <= irq_s1_r;
      irq_s3_r <= irq_s2_r;
    end
  end

  // A change counts only once the second and third stages agree
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      hb_r  <= host_bus_t'({16'h0000, 1'b0, 1'b1, 1'b1});
      irq_r <= 1'b1;
    end
    else
    begin
      if (hb_s2_r == hb_s3_r)
        hb_r <= hb_s3_r;
      if (irq_s2_r == irq_s3_r)
        irq_r <= irq_s3_r;
    end
  end

  // Full mode keeps its own address latch, loaded while host latch enable is high
  logic [ADDR_W-1:0] addr_latch_r;
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      addr_latch_r <= 16'h0000;
    else if (hb_r.latch_en)
      addr_latch_r <= hb_r.addr_data;
  end

  // Jumper compare value, caught after reset release rather than under reset
  logic [7:0] range_r;
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      range_r <= RANGE_SEL_DEFAULT;
    else
      range_r <= range_use_default ? RANGE_SEL_DEFAULT : range_select_jumpers;
  end

  // Address used for decoding: latched copy in full mode, live bus in minimal
  // mode where the chip itself latches on its own latch enable.
  logic [ADDR_W-1:0] dec_addr;
  logic              dec_enable;
  logic              is_full;

  always_comb
  begin
    is_full = (decode_mode == MODE_FULL);
    if (is_full)
    begin
      dec_addr   = addr_latch_r;
      // Upper byte must match the jumpers exactly; anything else keeps all
      // decoder outputs high so no stray access reaches the chip.
      dec_enable = (addr_latch_r[HI_BYTE_MSB:HI_BYTE_LSB] == range_r);
    end
    else
    begin
      dec_addr   = hb_r.addr_data;
      // Line nine high avoids internal RAM, line fifteen low avoids internal ROM
      dec_enable = hb_r.addr_data[LINE_NINE_BIT]
                   && !hb_r.addr_data[LINE_FIFTEEN_BIT];
    end
  end

  // Line decoder: first output to the chip, the rest to further peripherals
  logic [DEC_OUTS-1:0] dec_sel_n;

  line_decoder #(
    .OUTS (DEC_OUTS),
    .SW   (SEL_W)
  ) u_line_decoder (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .enable  (dec_enable),
    .select  (dec_addr[LINE_SEL_MSB:LINE_SEL_LSB]),
    .sel_n_r (dec_sel_n)
  );

  // Register select, byte select and strobes aligned with the decoder delay
  logic [REG_SEL_W-1:0] reg_sel_r;
  logic                 byte_sel_r;
  logic                 rd_n_r, wr_n_r, le_r;

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      reg_sel_r  <= '0;
      byte_sel_r <= 1'b0;
      rd_n_r     <= 1'b1;
      wr_n_r     <= 1'b1;
      le_r       <= 1'b1;
    end
    else
    begin
      reg_sel_r  <= dec_addr[REG_SEL_MSB:REG_SEL_LSB];
      // Lowest bit only matters in 8-bit width; 16-bit access ties it low
      byte_sel_r <= bus_width_select ? 1'b0 : dec_addr[BYTE_SEL_BIT];
      // Hold strobes off until chip select has been settled one cycle,
      // giving chip select lead time over the read and write edges.
      rd_n_r     <= hb_r.rd_n || dec_sel_n[CHIP_LINE];
      wr_n_r     <= hb_r.wr_n || dec_sel_n[CHIP_LINE];
      le_r       <= is_full ? 1'b1 : hb_r.latch_en;
    end
  end

  // Outputs to the chip port, the interrupt line and the peripherals
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      chip_port              <= chip_port_t'({1'b1, 1'b1, 4'h0, 1'b0, 1'b1, 1'b1});
      host_external_irq_line <= 1'b1;
      peripheral_sel_n       <= '1;
    end
    else
    begin
      chip_port.chip_sel_n    <= dec_sel_n[CHIP_LINE];
      chip_port.chip_latch_en <= le_r;
      chip_port.reg_sel       <= reg_sel_r;
      chip_port.byte_sel      <= byte_sel_r;
      // Gate again with the live select so a strobe never outlasts chip select
      chip_port.rd_n          <= rd_n_r || dec_sel_n[CHIP_LINE];
      chip_port.wr_n          <= wr_n_r || dec_sel_n[CHIP_LINE];
      host_external_irq_line  <= irq_r;
      peripheral_sel_n        <= dec_sel_n[DEC_OUTS-1:1];
    end
  end

endmodule // host_address_decoder

// ---- shared/addr_decode_pkg.sv ----
// Purpose: Constants and carrier types for the host-side address decode glue.
// Assumes: 16-bit multiplexed address/data host bus, one system clock.
// Notes:   Overview and numbering of the decode behaviour follow.
// Overview of operation
// - Full mode: latched address bits 15..8 must equal jumper value, default 02H.
// - Line decoder selects on latched address bits 5 to 7.
// - First decoder output drives active-low chip select for 0200H-021FH.
// - Address bits 1 to 4 pass straight to the chip register select.
// - In 16-bit access the chip's lowest address input is held low.
// - With external latches the chip's latch enable is held high.
// - Chip interrupt request is routed to one host external interrupt line.
// - Minimal mode: decoder enabled only while muxed line nine is one.
// - Minimal mode: decoder also requires muxed line fifteen to be zero.
// - Minimal mode register address pattern is 0XXX,XX1X,000P,PPP0.
// - Other decoder outputs may select further self-latching peripherals.
// - 8-bit mode: lowest address bit picks byte; ignored in 16-bit mode.
package addr_decode_pkg;

  localparam int          ADDR_W          = 16;
  localparam int          SEL_W           = 3;
  localparam int          DEC_OUTS        = 8;
  localparam int          REG_SEL_W       = 4;
  localparam logic [7:0]  RANGE_DEFAULT   = 8'h02;
  // Field positions on the host address
  localparam int          HI_BYTE_MSB     = 15;
  localparam int          HI_BYTE_LSB     = 8;
  localparam int          LINE_SEL_MSB    = 7;
  localparam int          LINE_SEL_LSB    = 5;
  localparam int          REG_SEL_MSB     = 4;
  localparam int          REG_SEL_LSB     = 1;
  localparam int          BYTE_SEL_BIT    = 0;
  localparam int          LINE_NINE_BIT   = 9;
  localparam int          LINE_FIFTEEN_BIT = 15;
  localparam logic [2:0]  CHIP_LINE       = 3'h0;
  // Decoded block and chip window, kept for reference; nothing in the project uses them
  localparam logic [15:0] BLOCK_BASE      = 16'h0200;
  localparam logic [15:0] BLOCK_LAST      = 16'h021F;
  localparam logic [15:0] CHIP_LAST       = 16'h021B;

  typedef enum logic [1:0] {
    MODE_FULL    = 2'b01,
    MODE_MINIMAL = 2'b10
  } decode_mode_t;

  // Host bus sample as seen on the pins
  typedef struct packed {
    logic [ADDR_W-1:0] addr_data;
    logic              latch_en;
    logic              rd_n;
    logic              wr_n;
  } host_bus_t;

  // Signals presented to the acquisition chip port
  typedef struct packed {
    logic                 chip_sel_n;
    logic                 chip_latch_en;
    logic [REG_SEL_W-1:0] reg_sel;
    logic                 byte_sel;
    logic                 rd_n;
    logic                 wr_n;
  } chip_port_t;

endpackage

// ---- rtl/line_decoder.sv ----
// Purpose: Registered 3-to-8 line decoder with enable, active-low outputs.
// Assumes: Select and enable are already in the clk_sys domain.
// Notes:   All outputs high when disabled, so no peripheral is selected.
module line_decoder #(
  parameter int OUTS = 8,
  parameter int SW   = 3
) (
  input  wire logic          clk_sys,
  input  wire logic          reset_n,
  input  wire logic          enable,
  input  wire logic [SW-1:0] select,
  output logic [OUTS-1:0]    sel_n_r
);

  // One output low per select code while enabled
  generate
    for (genvar i = 0; i < OUTS; i++)
    begin : g_out
      always_ff @(posedge clk_sys)
      begin
        if (!reset_n)
          sel_n_r[i] <= 1'b1;
        else
          sel_n_r[i] <= !(enable && (select == SW'(i)));
      end
    end
  endgenerate

endmodule // line_decoder

// ---- dv/hd_monitor.sv ----
// Purpose: Port checker for the host decoder.
// Assumes: Static inputs change rarely.
// Notes:   Decode checks wait until the bus has settled; the strobe gate checks run every cycle.
module hd_monitor
  import addr_decode_pkg::*;
#(
  parameter logic [7:0] RANGE_SEL_DEFAULT = RANGE_DEFAULT
) (
  input wire logic                          clk_sys,
  input wire logic                          reset_n,
  input wire addr_decode_pkg::decode_mode_t decode_mode,
  input wire logic                          bus_width_select,
  input wire logic [7:0]                    range_select_jumpers,
  input wire logic                          range_use_default,
  input wire addr_decode_pkg::host_bus_t    host_bus,
  input wire logic                          chip_irq_n,
  input wire addr_decode_pkg::chip_port_t   chip_port,
  input wire logic                          host_external_irq_line
);
  timeunit 1ns / 1ns;
  // Expected decode worked out from the live pins
  wire [15:0] a    = host_bus.addr_data;
  wire [7:0]  rng  = range_use_default ? RANGE_SEL_DEFAULT : range_select_jumpers;
  wire        hit  = (a[15:8] == rng) && (a[7:5] == 3'h0);
  wire        mhit = a[9] && !a[15] && (a[7:5] == 3'h0);
  wire        full = decode_mode == MODE_FULL;
  wire [11:0] cfg  = {decode_mode, bus_width_select, range_select_jumpers, range_use_default};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Eleven quiet samples, longer than the sync and decode pipeline
  sequence s_set;
    $stable({host_bus, cfg})[*8] ##1 $stable({host_bus, cfg})[*3];
  endsequence
  sequence s_full;
    s_set ##0 full && host_bus.latch_en;
  endsequence
  a_cs_inside:
    assert property (s_full ##0 hit |-> !chip_port.chip_sel_n) else $error("cs idle");
  a_cs_outside:
    assert property (s_full ##0 !hit |-> chip_port.chip_sel_n) else $error("cs stray");
  a_byte_pick:
    assert property (s_full |-> chip_port.byte_sel == (!bus_width_select && a[0]))
    else $error("byte sel");
  a_full_latch:
    assert property (s_set ##0 full |-> chip_port.chip_latch_en) else $error("latch low");
  a_min_decode:
    assert property (s_set ##0 !full |-> chip_port.chip_sel_n == !mhit) else $error("min cs");
  a_min_latch:
    assert property (s_set ##0 !full |-> chip_port.chip_latch_en == host_bus.latch_en)
    else $error("min latch");
  a_irq_route:
    assert property ($stable(chip_irq_n)[*7] |-> host_external_irq_line == chip_irq_n)
    else $error("irq route");
  a_strobe_gate:
    assert property (!chip_port.rd_n |-> !chip_port.chip_sel_n && !$past(chip_port.chip_sel_n))
    else $error("rd ungated");
  a_wr_gate:
    assert property (!chip_port.wr_n |-> !chip_port.chip_sel_n && !$past(chip_port.chip_sel_n))
    else $error("wr ungated");
endmodule // hd_monitor

bind host_address_decoder hd_monitor #(.RANGE_SEL_DEFAULT(RANGE_SEL_DEFAULT)) u_mon (
  .clk_sys, .reset_n, .decode_mode, .bus_width_select, .range_select_jumpers,
  .range_use_default, .host_bus, .chip_irq_n, .chip_port, .host_external_irq_line);

// ---- dv/chip_model.sv ----
// Purpose: Far-side model of the acquisition chip port.
// Assumes: A write raises the interrupt, a read clears it.
// Notes:   Byte select is ignored, as in word access.
module chip_model
  import addr_decode_pkg::*;
(
  input  wire logic                        clk_sys,
  input  wire logic                        reset_n,
  input  wire addr_decode_pkg::chip_port_t chip_port,
  output logic                             chip_irq_n
);
  timeunit 1ns / 1ns;
  logic [3:0] sel_r;
  // Address latch stays transparent while latch enable is high
  always_ff @(posedge clk_sys)
    if (chip_port.chip_latch_en)
      sel_r <= chip_port.reg_sel;
  // Only the 14 word registers answer; the tail of the block is unused
  always_ff @(posedge clk_sys)
    if (!reset_n)
      chip_irq_n <= 1'b1;
    // Accesses only count while selected; the real chip pauses its clock then
    else if (!chip_port.chip_sel_n && sel_r < 4'hE)
      chip_irq_n <= chip_port.wr_n ? (chip_irq_n | !chip_port.rd_n) : 1'b0;
endmodule // chip_model

// ---- dv/host_address_decoder_tb_top.sv ----
// Purpose: Self-checking bench for the host decoder.
// Assumes: One clock, chip model on the far side.
// Notes:   Each bus state is held well past the sync flops.
module host_address_decoder_tb_top;
  timeunit 1ns / 1ns;
  import addr_decode_pkg::*;
  logic         clk_sys = 1'b0;
  logic         reset_n = 1'b0;
  decode_mode_t decode_mode = MODE_FULL;
  logic         bus_width_select = 1'b1;
  logic [7:0]   range_select_jumpers = 8'h05;
  logic         range_use_default = 1'b1;
  host_bus_t    host_bus = 19'h00007;
  chip_port_t   chip_port;
  logic         chip_irq_n;
  logic         host_external_irq_line;
  logic [6:0]   peripheral_sel_n;
  int           errors = 0;
  int           samples_checked = 0;
  logic [15:0]  ftbl [8] = '{16'h0200, 16'h021B, 16'h021F, 16'h0220,
                             16'h01FF, 16'h0300, 16'h02E7, 16'h0205};
  logic [15:0]  mtbl [6] = '{16'h0200, 16'h7E1E, 16'h8200, 16'h01FE, 16'h0220, 16'hFE00};
  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;
  host_address_decoder dut (.clk_sys, .reset_n, .decode_mode, .bus_width_select,
    .range_select_jumpers, .range_use_default, .host_bus, .chip_irq_n, .chip_port,
    .host_external_irq_line, .peripheral_sel_n);
  chip_model chip (.clk_sys, .reset_n, .chip_port, .chip_irq_n);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  // Control bits are latch enable, read strobe, write strobe
  task automatic put(input logic [15:0] a, input logic [2:0] ctl);
    @(posedge clk_sys);
    host_bus <= {a, ctl};
    repeat (16) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_full();
    logic [15:0] a;
    logic [7:0]  ln;
    for (int w = 0; w < 2; w++)
    begin
      @(posedge clk_sys);
      bus_width_select <= w[0];
      foreach (ftbl[i])
      begin
        a = ftbl[i];
        ln = ~(8'h01 << a[7:5]);
        put(a, 3'b111);
        check(chip_port.chip_sel_n, !(a[15:8] == 8'h02 && a[7:5] == 3'h0));
        check(chip_port.reg_sel, a[4:1]);
        check(chip_port.byte_sel, !bus_width_select && a[0]);
        check(chip_port.chip_latch_en, 1'b1);
        check(peripheral_sel_n, a[15:8] == 8'h02 ? ln[7:1] : 7'h7F);
      end
    end
    @(posedge clk_sys);
    range_use_default <= 1'b0;
    put(16'h0500, 3'b111);
    check(chip_port.chip_sel_n, 1'b0);
    put(16'h0200, 3'b111);
    check(chip_port.chip_sel_n, 1'b1);
    @(posedge clk_sys);
    range_use_default <= 1'b1;
  endtask
  // Latched read, write raising the interrupt, read clearing it
  task automatic t_strobe();
    put(16'h0204, 3'b111);
    put(16'h0204, 3'b001);
    check({chip_port.chip_sel_n, chip_port.rd_n, chip_port.reg_sel}, 6'h02);
    put(16'h0204, 3'b010);
    check({chip_port.wr_n, host_external_irq_line}, 2'h0);
    put(16'h0204, 3'b001);
    check(host_external_irq_line, 1'b1);
    put(16'h0300, 3'b101);
    check({chip_port.chip_sel_n, chip_port.rd_n}, 2'h3);
  endtask
  task automatic t_min();
    logic [15:0] a;
    logic [7:0]  ln;
    @(posedge clk_sys);
    decode_mode <= MODE_MINIMAL;
    foreach (mtbl[i])
    begin
      a = mtbl[i];
      put(a, {i[0], 2'b11});
      check(chip_port.chip_sel_n, !(a[9] && !a[15] && a[7:5] == 3'h0));
      check(chip_port.chip_latch_en, i[0]);
      ln = ~(8'h01 << a[7:5]);
      check(peripheral_sel_n, (a[9] && !a[15]) ? ln[7:1] : 7'h7F);
    end
  endtask
  task automatic results();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Reset for three cycles, then the scenarios
  initial
  begin
    repeat (2) @(posedge clk_sys);
    #1;
    check({chip_port.chip_sel_n, peripheral_sel_n}, 8'hFF);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    t_full();
    t_strobe();
    t_min();
    results();
  end
  // Watchdog, far beyond the roughly 500 cycles the run needs
  initial
  begin
    #100000;
    errors++;
    results();
  end
endmodule // host_address_decoder_tb_top
